// File: common/csc_pkg.sv
// Constants for the current-sense calibration register bank
package csc_pkg;
   // Command codes of the bank
   localparam logic [7:0] CMD_PHASE0_SENSE_GAIN = 8'hca;
   localparam logic [7:0] CMD_PHASE1_SENSE_GAIN = 8'hcb;
   localparam logic [7:0] CMD_PHASE0_SENSE_OFFSET = 8'hcc;
   localparam logic [7:0] CMD_PHASE1_SENSE_OFFSET = 8'hcd;
   localparam logic [7:0] CMD_RAMP_VOLTAGE_FLOOR = 8'hce;
   // Word slots, in command-code order
   localparam int NUM_WORDS = 5;
   localparam logic [2:0] IDX_PHASE0_SENSE_GAIN = 3'h0;
   localparam logic [2:0] IDX_PHASE1_SENSE_GAIN = 3'h1;
   localparam logic [2:0] IDX_PHASE0_SENSE_OFFSET = 3'h2;
   localparam logic [2:0] IDX_PHASE1_SENSE_OFFSET = 3'h3;
   localparam logic [2:0] IDX_RAMP_VOLTAGE_FLOOR = 3'h4;
   // Reset values: 0.3 mOhm gains, 0 A offsets, 150 mV floor
   localparam logic [15:0] RST_SENSE_GAIN = 16'haa66;
   localparam logic [15:0] RST_SENSE_OFFSET = 16'h0000;
   localparam logic [15:0] RST_RAMP_VOLTAGE_FLOOR = 16'hf258;
   // Word layout: exponent and mantissa fields
   localparam int EXP_MSB = 15;
   localparam int EXP_LSB = 11;
   localparam int EXP_W = 5;
   localparam int MANT_MSB = 10;
   localparam int MANT_LSB = 0;
   localparam int MANT_W = 11;
   // Data bytes per word transfer
   localparam logic [1:0] WORD_BYTES = 2'h2;
   // Transaction states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACTIVE = 2'b10
   } csc_state_t;
endpackage

// File: rtl/csc_lin11_split.sv
// Splits one stored word into its signed exponent and mantissa
`timescale 1ns/10ps
module csc_lin11_split (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Stored word
   input wire logic [15:0] word,
   // Decoded fields
   output logic signed [csc_pkg::EXP_W-1:0] exponent,
   output logic signed [csc_pkg::MANT_W-1:0] mantissa
);
   import csc_pkg::*;

   // Field split, registered for the datapath
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         exponent <= '0;
         mantissa <= '0;
      end else begin
         exponent <= signed'(word[EXP_MSB:EXP_LSB]);
         mantissa <= signed'(word[MANT_MSB:MANT_LSB]);
      end
   end

   property p_field_split;
      @(posedge mclk) disable iff (!nrst)
      $past(nrst) |-> (exponent == $past(word[EXP_MSB:EXP_LSB])) && (mantissa == $past(word[MANT_MSB:MANT_LSB]));
   endproperty
   a_field_split: assert property (p_field_split) else $error("field split mismatch");

   property p_sign_kept;
      @(posedge mclk) disable iff (!nrst)
      $past(nrst) && $past(word[EXP_MSB]) |-> exponent < 0;
   endproperty
   a_sign_kept: assert property (p_sign_kept) else $error("exponent sign lost");
endmodule

// File: rtl/csc_regs.sv
// Current-sense calibration register bank behind the management bus command port
// Overview of operation
// - Command CBh is a read/write word holding the phase 1 sense impedance in milliohms.
// - The phase 1 sense-gain word resets to AA66h, i.e. 0.3 milliohm.
// - Command CCh is a read/write word holding the phase 0 current offset in amperes.
// - Command CDh is the matching read/write current offset word for phase 1.
// - Both current offset words reset to 0000h, i.e. zero amperes.
// - Command CEh is a read/write word holding the lowest ramp target voltage in millivolts.
// - The ramp voltage floor resets to F258h, i.e. 150 millivolts.
// - Every word is a signed mantissa times two to a signed exponent.
// - Every word write takes exactly two data bytes; a read returns low then high byte and wraps back to low on a third request.
// - Every word is readable and writable, and writes are refused while write protection is on.
// - Command CAh is the phase 0 sense-gain word with the same format and reset value.
`timescale 1ns/10ps
module csc_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Command port from the bus protocol engine
   input wire logic cmd_start,
   input wire logic [7:0] cmd_code,
   input wire logic txn_stop,
   input wire logic write_protect,
   // Write bytes, low byte first
   input wire logic wr_byte_valid,
   input wire logic [7:0] wr_byte,
   // Read bytes, low byte first
   input wire logic rd_byte_req,
   output logic [7:0] rd_byte,
   output logic rd_byte_valid,
   // Transaction status
   output logic cmd_supported,
   output logic wr_refused,
   // Stored words
   output logic [15:0] phase0_sense_gain,
   output logic [15:0] phase1_sense_gain,
   output logic [15:0] phase0_sense_offset,
   output logic [15:0] phase1_sense_offset,
   output logic [15:0] ramp_voltage_floor,
   // Decoded fields, one slot per word, slot 0 in the low bits
   output logic [csc_pkg::NUM_WORDS*csc_pkg::EXP_W-1:0] word_exponent,
   output logic [csc_pkg::NUM_WORDS*csc_pkg::MANT_W-1:0] word_mantissa
);
   import csc_pkg::*;

   // Maps a command code onto a word slot; bit 3 flags a hit
   function automatic logic [3:0] code_slot(input logic [7:0] code);
      case (code)
         CMD_PHASE0_SENSE_GAIN: code_slot = {1'b1, IDX_PHASE0_SENSE_GAIN};
         CMD_PHASE1_SENSE_GAIN: code_slot = {1'b1, IDX_PHASE1_SENSE_GAIN};
         CMD_PHASE0_SENSE_OFFSET: code_slot = {1'b1, IDX_PHASE0_SENSE_OFFSET};
         CMD_PHASE1_SENSE_OFFSET: code_slot = {1'b1, IDX_PHASE1_SENSE_OFFSET};
         CMD_RAMP_VOLTAGE_FLOOR: code_slot = {1'b1, IDX_RAMP_VOLTAGE_FLOOR};
         default: code_slot = 4'h0;
      endcase
   endfunction

   // Reset value of each slot
   function automatic logic [15:0] slot_reset(input int idx);
      case (idx)
         0, 1: slot_reset = RST_SENSE_GAIN;
         2, 3: slot_reset = RST_SENSE_OFFSET;
         default: slot_reset = RST_RAMP_VOLTAGE_FLOOR;
      endcase
   endfunction

   csc_state_t state_reg;
   logic [7:0] cmd_reg;
   logic [1:0] wr_count_reg;
   logic rd_idx_reg;
   logic [15:0] wdata_reg;
   logic [15:0] words_reg [NUM_WORDS];
   logic [3:0] slot;
   logic commit;

   // Current command decode
   assign slot = code_slot(cmd_reg);
   assign cmd_supported = slot[3] && (state_reg == ST_ACTIVE);
   assign commit = (state_reg == ST_ACTIVE) && txn_stop && (wr_count_reg == WORD_BYTES) && slot[3]
                   && !write_protect;

   // Transaction tracking
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         cmd_reg <= 8'h00;
      end else if (cmd_start) begin
         state_reg <= ST_ACTIVE;
         cmd_reg <= cmd_code;
      end else if (txn_stop) begin
         state_reg <= ST_IDLE;
      end
   end

   // Write byte gathering, counter saturates to catch long writes
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wr_count_reg <= 2'h0;
         wdata_reg <= 16'h0000;
      end else if (cmd_start) begin
         wr_count_reg <= 2'h0;
      end else if (wr_byte_valid && state_reg == ST_ACTIVE) begin
         if (wr_count_reg == 2'h0) begin
            wdata_reg[7:0] <= wr_byte;
         end else if (wr_count_reg == 2'h1) begin
            wdata_reg[15:8] <= wr_byte;
         end
         if (wr_count_reg != 2'h3) begin
            wr_count_reg <= wr_count_reg + 2'h1;
         end
      end
   end

   // Word storage with reset values
   always_ff @(posedge mclk) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
         if (!nrst) begin
            words_reg[i] <= slot_reset(i);
         end else if (commit && slot[2:0] == i[2:0]) begin
            words_reg[i] <= wdata_reg;
         end
      end
   end

   // Refusal pulse for protected, unknown or wrongly sized writes
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wr_refused <= 1'b0;
      end else begin
         wr_refused <= (state_reg == ST_ACTIVE) && txn_stop && (wr_count_reg != 2'h0) && !commit;
      end
   end

   // Read bytes, low then high; unknown codes read zero
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rd_idx_reg <= 1'b0;
         rd_byte <= 8'h00;
         rd_byte_valid <= 1'b0;
      end else begin
         // A request in the cycle of a new command is dropped, so no stale byte is flagged
         rd_byte_valid <= rd_byte_req && state_reg == ST_ACTIVE && !cmd_start;
         if (cmd_start) begin
            rd_idx_reg <= 1'b0;
         end else if (rd_byte_req && state_reg == ST_ACTIVE) begin
            rd_idx_reg <= !rd_idx_reg;
            if (!slot[3]) begin
               rd_byte <= 8'h00;
            end else if (!rd_idx_reg) begin
               rd_byte <= words_reg[slot[2:0]][7:0];
            end else begin
               rd_byte <= words_reg[slot[2:0]][15:8];
            end
         end
      end
   end

   // Named word outputs
   assign phase0_sense_gain = words_reg[IDX_PHASE0_SENSE_GAIN];
   assign phase1_sense_gain = words_reg[IDX_PHASE1_SENSE_GAIN];
   assign phase0_sense_offset = words_reg[IDX_PHASE0_SENSE_OFFSET];
   assign phase1_sense_offset = words_reg[IDX_PHASE1_SENSE_OFFSET];
   assign ramp_voltage_floor = words_reg[IDX_RAMP_VOLTAGE_FLOOR];

   // Field decoders, one per word
   generate
      for (genvar g = 0; g < NUM_WORDS; g++) begin : g_split
         csc_lin11_split u_split (
            .mclk(mclk),
            .nrst(nrst),
            .word(words_reg[g]),
            .exponent(word_exponent[g*EXP_W +: EXP_W]),
            .mantissa(word_mantissa[g*MANT_W +: MANT_W])
         );
      end
   endgenerate

   property p_gain_reset;
      @(posedge mclk) $rose(nrst) |-> phase1_sense_gain == RST_SENSE_GAIN && phase0_sense_gain == RST_SENSE_GAIN;
   endproperty
   a_gain_reset: assert property (p_gain_reset) else $error("gain reset value wrong");

   property p_gain0_write;
      @(posedge mclk) disable iff (!nrst)
      commit && cmd_reg == CMD_PHASE0_SENSE_GAIN |=> phase0_sense_gain == $past(wdata_reg);
   endproperty
   a_gain0_write: assert property (p_gain0_write) else $error("phase 0 gain not written");

   property p_offset_reset;
      @(posedge mclk) $rose(nrst) |-> phase0_sense_offset == RST_SENSE_OFFSET && phase1_sense_offset == RST_SENSE_OFFSET;
   endproperty
   a_offset_reset: assert property (p_offset_reset) else $error("offset reset value wrong");

   property p_floor_reset;
      @(posedge mclk) $rose(nrst) |-> ramp_voltage_floor == RST_RAMP_VOLTAGE_FLOOR;
   endproperty
   a_floor_reset: assert property (p_floor_reset) else $error("floor reset value wrong");

   property p_gain1_write;
      @(posedge mclk) disable iff (!nrst)
      commit && cmd_reg == CMD_PHASE1_SENSE_GAIN |=> phase1_sense_gain == $past(wdata_reg);
   endproperty
   a_gain1_write: assert property (p_gain1_write) else $error("phase 1 gain not written");

   property p_offset_write;
      @(posedge mclk) disable iff (!nrst)
      commit && (cmd_reg == CMD_PHASE0_SENSE_OFFSET || cmd_reg == CMD_PHASE1_SENSE_OFFSET) |=>
         (($past(cmd_reg) == CMD_PHASE0_SENSE_OFFSET) ? phase0_sense_offset : phase1_sense_offset)
         == $past(wdata_reg);
   endproperty
   a_offset_write: assert property (p_offset_write) else $error("offset not written");

   property p_protect_holds;
      @(posedge mclk) disable iff (!nrst)
      write_protect && !cmd_start |=> $stable(phase1_sense_gain) && $stable(phase0_sense_offset)
         && $stable(phase1_sense_offset) && $stable(ramp_voltage_floor) && $stable(phase0_sense_gain);
   endproperty
   a_protect_holds: assert property (p_protect_holds) else $error("write taken under protection");

   property p_byte_count;
      @(posedge mclk) disable iff (!nrst)
      state_reg == ST_ACTIVE && txn_stop && wr_count_reg != 2'h2 |=> $stable(ramp_voltage_floor)
         && $stable(phase1_sense_gain);
   endproperty
   a_byte_count: assert property (p_byte_count) else $error("write with wrong byte count taken");

   property p_floor_read;
      @(posedge mclk) disable iff (!nrst)
      rd_byte_req && state_reg == ST_ACTIVE && cmd_reg == CMD_RAMP_VOLTAGE_FLOOR && !rd_idx_reg && !cmd_start
         && !txn_stop ##1 rd_byte_req && !txn_stop && !cmd_start
         |=> rd_byte_valid && rd_byte == $past(ramp_voltage_floor[15:8], 1)
         && $past(rd_byte, 1) == $past(ramp_voltage_floor[7:0], 2);
   endproperty
   a_floor_read: assert property (p_floor_read) else $error("floor read bytes wrong");
endmodule

// File: test/csc_host_model.sv
// Management bus host model driving the calibration bank command port
`timescale 1ns/10ps
module csc_host_model (
   // Clock
   input wire logic mclk,
   // Command port toward the bank
   output logic cmd_start,
   output logic [7:0] cmd_code,
   output logic txn_stop,
   output logic wr_byte_valid,
   output logic [7:0] wr_byte,
   output logic rd_byte_req
);
   // Idle levels at time zero
   initial begin
      cmd_start = 1'b0;
      cmd_code = 8'h00;
      txn_stop = 1'b0;
      wr_byte_valid = 1'b0;
      wr_byte = 8'h00;
      rd_byte_req = 1'b0;
   end

   // One edge, then the fixed drive delay
   task automatic step();
      @(posedge mclk);
      #1;
   endtask

   // Open a transaction; released code is scrambled
   task automatic open_txn(input logic [7:0] code);
      cmd_start = 1'b1;
      cmd_code = code;
      step();
      cmd_start = 1'b0;
      cmd_code = ~code;
   endtask

   // Close a transaction with a one-cycle stop
   task automatic close_txn();
      txn_stop = 1'b1;
      step();
      txn_stop = 1'b0;
   endtask

   // Word write, low byte first, optional gap between bytes
   task automatic write_word(input logic [7:0] code, input logic [23:0] data, input int nbytes, input int gap);
      open_txn(code);
      for (int i = 0; i < nbytes; i++) begin
         wr_byte = data[8*i +: 8];
         wr_byte_valid = 1'b1;
         step();
         if (gap != 0) begin
            wr_byte_valid = 1'b0;
            wr_byte = ~wr_byte;
            repeat (gap) step();
         end
      end
      wr_byte_valid = 1'b0;
      wr_byte = ~wr_byte;
      close_txn();
   endtask

   // Word read of two bytes
   task automatic read_word(input logic [7:0] code, input int gap);
      open_txn(code);
      for (int i = 0; i < 2; i++) begin
         rd_byte_req = 1'b1;
         step();
         if (gap != 0) begin
            rd_byte_req = 1'b0;
            repeat (gap) step();
         end
      end
      rd_byte_req = 1'b0;
      close_txn();
   endtask
endmodule

// File: test/csc_regs_test.sv
// Self-checking bench for the calibration register bank
`timescale 1ns/10ps
module csc_regs_test;
   import csc_pkg::*;
   logic mclk, nrst, write_protect, cmd_start, txn_stop, wr_byte_valid, rd_byte_req;
   logic [7:0] cmd_code, wr_byte, rd_byte;
   logic rd_byte_valid, cmd_supported, wr_refused;
   logic [15:0] word_q [5];
   logic [24:0] word_exponent;
   logic [54:0] word_mantissa;
   logic [7:0] exp_q [$];
   logic sup_q [$];
   logic [15:0] exp_w [5];
   logic [7:0] codes [5] = '{8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce};
   logic [31:0] lfsr = 32'h86a9960f;
   int miscompares = 0;
   int checks_done = 0;
   int ref_seen = 0;
   int ref_exp = 0;

   // Clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   csc_regs dut_u (.mclk(mclk), .nrst(nrst), .cmd_start(cmd_start), .cmd_code(cmd_code), .txn_stop(txn_stop),
      .write_protect(write_protect), .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_req(rd_byte_req),
      .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid), .cmd_supported(cmd_supported), .wr_refused(wr_refused),
      .phase0_sense_gain(word_q[0]), .phase1_sense_gain(word_q[1]), .phase0_sense_offset(word_q[2]),
      .phase1_sense_offset(word_q[3]), .ramp_voltage_floor(word_q[4]), .word_exponent(word_exponent),
      .word_mantissa(word_mantissa));

   csc_host_model u_host (.mclk(mclk), .cmd_start(cmd_start), .cmd_code(cmd_code), .txn_stop(txn_stop),
      .wr_byte_valid(wr_byte_valid), .wr_byte(wr_byte), .rd_byte_req(rd_byte_req));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check8(input logic [7:0] got, input logic [7:0] want);
      checks_done++;
      if (got !== want) begin
         miscompares++;
         $display("FAIL %0t byte got %h want %h", $time, got, want);
      end
   endtask

   task automatic check1(input logic got, input logic want);
      checks_done++;
      if (got !== want) begin
         miscompares++;
         $display("FAIL %0t flag got %b want %b", $time, got, want);
      end
   endtask

   task automatic check16(input logic [15:0] got, input logic [15:0] want);
      checks_done++;
      if (got !== want) begin
         miscompares++;
         $display("FAIL %0t word got %h want %h", $time, got, want);
      end
   endtask

   task automatic step(input int n);
      repeat (n) begin
         @(posedge mclk);
         #1;
      end
   endtask

   // Note both expected bytes, low first, then read
   task automatic read_chk(input logic [7:0] code, input logic [15:0] want, input int gap);
      exp_q.push_back(want[7:0]);
      exp_q.push_back(want[15:8]);
      sup_q.push_back(code >= CMD_PHASE0_SENSE_GAIN && code <= CMD_RAMP_VOLTAGE_FLOOR);
      sup_q.push_back(code >= CMD_PHASE0_SENSE_GAIN && code <= CMD_RAMP_VOLTAGE_FLOOR);
      u_host.read_word(code, gap);
   endtask

   task automatic test_done();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Output watcher: read bytes against the oldest note, refusal pulses counted
   always @(posedge mclk) begin
      if (rd_byte_valid === 1'b1) begin
         if (exp_q.size() == 0 || sup_q.size() == 0) begin
            miscompares++;
            $display("FAIL %0t unexpected read byte", $time);
         end else begin
            check8(rd_byte, exp_q.pop_front());
            check1(cmd_supported, sup_q.pop_front());
         end
      end
      if (wr_refused === 1'b1)
         ref_seen++;
   end

   // Watchdog
   initial begin
      #400000;
      miscompares++;
      $display("FAIL %0t watchdog expired", $time);
      test_done();
   end

   initial begin
      nrst = 1'b0;
      write_protect = 1'b0;
      exp_w = '{16'haa66, 16'haa66, 16'h0000, 16'h0000, 16'hf258};
      step(12);
      nrst = 1'b1;
      // Reset values at the ports and over the bus
      for (int i = 0; i < 5; i++) check16(word_q[i], exp_w[i]);
      for (int i = 0; i < 5; i++) read_chk(codes[i], exp_w[i], 0);
      // Random words, prompt then slow host, with field decode
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            exp_w[i] = lfsr[15:0];
            u_host.write_word(codes[i], {8'h00, exp_w[i]}, 2, p);
            step(2);
            check16(word_q[i], exp_w[i]);
            check16({11'h000, word_exponent[i*EXP_W +: EXP_W]}, {11'h000, exp_w[i][15:11]});
            check16({5'h00, word_mantissa[i*MANT_W +: MANT_W]}, {5'h00, exp_w[i][10:0]});
            read_chk(codes[i], exp_w[i], p);
         end
      end
      check16(16'(ref_seen), 16'(ref_exp));
      // Protected writes are refused and change nothing
      write_protect = 1'b1;
      for (int i = 0; i < 5; i++) u_host.write_word(codes[i], {8'h00, ~exp_w[i]}, 2, 0);
      write_protect = 1'b0;
      ref_exp += 5;
      // Wrong byte counts and an unknown code
      u_host.write_word(codes[1], 24'h123456, 1, 0);
      u_host.write_word(codes[3], 24'h123456, 3, 0);
      u_host.write_word(8'hcf, 24'h001234, 2, 0);
      ref_exp += 3;
      step(2);
      check16(16'(ref_seen), 16'(ref_exp));
      for (int i = 0; i < 5; i++) read_chk(codes[i], exp_w[i], 0);
      read_chk(8'hc9, 16'h0000, 0);
      // Reset in mid-run brings every written word back to its reset value
      nrst = 1'b0;
      step(2);
      nrst = 1'b1;
      exp_w = '{16'haa66, 16'haa66, 16'h0000, 16'h0000, 16'hf258};
      for (int i = 0; i < 5; i++) check16(word_q[i], exp_w[i]);
      read_chk(codes[4], exp_w[4], 0);
      step(4);
      check16(16'(exp_q.size()), 16'h0000);
      check16(16'(sup_q.size()), 16'h0000);
      test_done();
   end
endmodule
